// [rtl/fanp_irq.sv]
// Sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ps
module fanp_irq #(
	parameter int W = fanp_pkg::IRQ_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] event_in,
	input wire logic clr_we,
	input wire logic en_we,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] status_q,
	output logic [W-1:0] enable_q,
	output logic irq
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Set wins over a simultaneous clear
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					status_q[i] <= 1'b0;
				end else if (event_in[i]) begin
					status_q[i] <= 1'b1;
				end else if (clr_we && wdata[i]) begin
					status_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enable_q <= '0;
		end else if (en_we) begin
			enable_q <= wdata;
		end
	end

	assign irq = |(status_q & enable_q);
endmodule

// [rtl/fanp_match.sv]
// Counts consecutive matching non-zero valid configuration groups
`timescale 1ns/1ps
module fanp_match (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sw_clr,
	input wire fanp_pkg::fanp_rx_s rx,
	output logic able
);
	logic [15:0] last_q;
	logic [1:0] cnt_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last_q <= 16'h0000;
			cnt_q <= 2'h0;
		end else if (sw_clr || !rx.sync_ok || !rx.an_enable) begin
			last_q <= 16'h0000;
			cnt_q <= 2'h0;
		end else if (rx.group_valid) begin
			last_q <= rx.group;
			if (rx.group == 16'h0000) begin
				cnt_q <= 2'h0;
			end else if (rx.group != last_q) begin
				cnt_q <= 2'h1;
			end else if (cnt_q != fanp_pkg::MATCH_NEED) begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end

	// Only while sync and enable still hold
	assign able = rx.sync_ok && rx.an_enable &&
		(cnt_q == fanp_pkg::MATCH_NEED);
endmodule

// [rtl/fanp_pkg.sv]
// Package for the fiber negotiation expansion and next-page register bank
package fanp_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [4:0] OFF_LP_BASE = 5'h05;
	localparam logic [4:0] OFF_EXP = 5'h06;
	localparam logic [4:0] OFF_NP_TX = 5'h07;
	localparam logic [4:0] OFF_NP_RX = 5'h08;
	localparam logic [4:0] OFF_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFF_IRQ_CLR = 5'h11;
	localparam logic [4:0] OFF_IRQ_EN = 5'h12;
	localparam logic [4:0] OFF_SW_RST = 5'h13;

	// Expansion register bit positions
	localparam int EXP_AN_ABLE = 0;
	localparam int EXP_PAGE_RX = 1;
	localparam int EXP_LOCAL_NP = 2;
	localparam int EXP_LP_NP = 3;

	// Code word bit positions
	localparam int CW_NP = 15;
	localparam int CW_TOGGLE = 11;
	localparam int SGMII_LOW_W = 7;

	// Next page transmit reset and writable mask
	localparam logic [15:0] NP_TX_RST = 16'h2001;
	localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;

	// Matching code groups needed for partner ability
	localparam logic [1:0] MATCH_NEED = 2'h3;

	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_PAGE = 0;
	localparam int IRQ_NP = 1;
	localparam int IRQ_LINK_DN = 2;
	localparam int IRQ_AN_ABLE = 3;

	typedef enum logic [1:0] {
		MODE_100FX = 2'h0,
		MODE_1000X = 2'h1,
		MODE_SGMII_SYS = 2'h2,
		MODE_SGMII_MED = 2'h3
	} fanp_mode_e;

	typedef struct packed {
		logic page_valid;
		logic is_next_page;
		logic [15:0] code_word;
	} fanp_page_s;

	typedef struct packed {
		logic sync_ok;
		logic link_up;
		logic an_enable;
		logic group_valid;
		logic [15:0] group;
	} fanp_rx_s;

endpackage

// [rtl/fanp_regs.sv]
// Fiber negotiation expansion, next-page transmit and receive registers
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Contract
// - SGMII media: low seven received bits tracked
// - Partner next-page flag zero in SGMII, 100FX
// - 1000X: set flag on bit15 page, link-loss clear
// - Local next-page able always reads one
// - Page received flag latches on valid page
// - Partner AN able needs sync, enable, 3 groups
// - Next-page transmit write flags page loaded
// - Transmit page applies only in 1000X mode
// - Transmit fields as written, bit 14 zero, bit 11 reads toggle
// - Toggle bit inverts on each received page
// - Received next page loads on next pages only
// - Received next page clears on link down
// - Received fields stored in place, read-only
// - Received next page loads only in 1000X
// - Mode field encodes the four fiber modes
module fanp_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [1:0] fiber_mode,
	input wire fanp_pkg::fanp_rx_s rx,
	input wire fanp_pkg::fanp_page_s page,
	input wire logic np_tx_taken,
	output logic np_loaded,
	output logic np_tx_active,
	output logic [15:0] np_tx_word,
	output logic irq
);
	fanp_pkg::fanp_mode_e mode;
	logic is_1000x;
	logic link_dn;
	logic link_q;
	logic sw_rst;
	logic an_able;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic [15:0] np_tx_q;
	logic toggle_q;
	logic loaded_q;
	logic page_rx_q;
	logic lp_np_q;
	logic [15:0] np_rx_q;
	logic [6:0] sgmii_low_q;
	logic [15:0] exp_val;
	logic [fanp_pkg::IRQ_W-1:0] irq_ev;
	logic [fanp_pkg::IRQ_W-1:0] irq_stat;
	logic [fanp_pkg::IRQ_W-1:0] irq_en;

	assign mode = fanp_pkg::fanp_mode_e'(fiber_mode);
	assign is_1000x = (mode == fanp_pkg::MODE_1000X);
	assign link_dn = link_q && !rx.link_up;
	assign sw_rst = wr && (addr == fanp_pkg::OFF_SW_RST) && wdata[0];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link_q <= 1'b0;
		end else begin
			link_q <= rx.link_up;
		end
	end

	fanp_match u_match (
		.clk_sys(clk_sys),
		.rst(rst),
		.sw_clr(sw_rst),
		.rx(rx),
		.able(an_able)
	);

	// Next page transmit register; bit 14 never stored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			np_tx_q <= fanp_pkg::NP_TX_RST;
		end else if (sw_rst) begin
			np_tx_q <= fanp_pkg::NP_TX_RST;
		end else if (wr && addr == fanp_pkg::OFF_NP_TX) begin
			np_tx_q <= wdata & fanp_pkg::NP_TX_WMASK;
		end
	end

	// Toggle flips on every received page
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			toggle_q <= 1'b0;
		end else if (sw_rst) begin
			toggle_q <= 1'b0;
		end else if (page.page_valid) begin
			toggle_q <= !toggle_q;
		end
	end

	// Page loaded flag toward negotiation state machine
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			loaded_q <= 1'b0;
		end else if (sw_rst || link_dn) begin
			loaded_q <= 1'b0;
		end else if (wr && addr == fanp_pkg::OFF_NP_TX) begin
			loaded_q <= 1'b1;
		end else if (np_tx_taken) begin
			loaded_q <= 1'b0;
		end
	end

	assign np_loaded = loaded_q && is_1000x;
	assign np_tx_active = is_1000x;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			np_tx_word <= 16'h0000;
		end else begin
			np_tx_word <= np_tx_q;
			np_tx_word[fanp_pkg::CW_TOGGLE] <= toggle_q;
		end
	end

	// Latched-high page received; new page beats read clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			page_rx_q <= 1'b0;
		end else if (page.page_valid) begin
			page_rx_q <= 1'b1;
		end else if (sw_rst ||
			(rd && addr == fanp_pkg::OFF_EXP)) begin
			page_rx_q <= 1'b0;
		end
	end

	// Partner next-page able
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lp_np_q <= 1'b0;
		end else if (!is_1000x || sw_rst || link_dn) begin
			lp_np_q <= 1'b0;
		end else if (page.page_valid && !page.is_next_page) begin
			lp_np_q <= page.code_word[fanp_pkg::CW_NP];
		end
	end

	// Partner next page received register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			np_rx_q <= 16'h0000;
		end else if (sw_rst || link_dn) begin
			np_rx_q <= 16'h0000;
		end else if (page.page_valid && page.is_next_page &&
			is_1000x) begin
			np_rx_q <= page.code_word;
		end
	end

	// SGMII media base-page low bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sgmii_low_q <= 7'h00;
		end else if (sw_rst || link_dn) begin
			sgmii_low_q <= 7'h00;
		end else if (page.page_valid && !page.is_next_page &&
			mode == fanp_pkg::MODE_SGMII_MED) begin
			sgmii_low_q <=
				page.code_word[fanp_pkg::SGMII_LOW_W-1:0];
		end
	end

	always_comb begin
		exp_val = 16'h0000;
		exp_val[fanp_pkg::EXP_AN_ABLE] = an_able;
		exp_val[fanp_pkg::EXP_PAGE_RX] = page_rx_q;
		exp_val[fanp_pkg::EXP_LOCAL_NP] = 1'b1;
		exp_val[fanp_pkg::EXP_LP_NP] = lp_np_q && is_1000x;
	end

	assign irq_ev[fanp_pkg::IRQ_PAGE] = page.page_valid;
	assign irq_ev[fanp_pkg::IRQ_NP] = page.page_valid &&
		page.is_next_page && is_1000x;
	assign irq_ev[fanp_pkg::IRQ_LINK_DN] = link_dn;
	assign irq_ev[fanp_pkg::IRQ_AN_ABLE] = an_able;

	fanp_irq #(
		.W(fanp_pkg::IRQ_W)
	) u_irq (
		.clk_sys(clk_sys),
		.rst(rst),
		.event_in(irq_ev),
		.clr_we(wr && addr == fanp_pkg::OFF_IRQ_CLR),
		.en_we(wr && addr == fanp_pkg::OFF_IRQ_EN),
		.wdata(wdata[fanp_pkg::IRQ_W-1:0]),
		.status_q(irq_stat),
		.enable_q(irq_en),
		.irq(irq)
	);

	always_comb begin
		rdata_d = 16'h0000;
		unique case (addr)
			fanp_pkg::OFF_LP_BASE: begin
				rdata_d[fanp_pkg::SGMII_LOW_W-1:0] = sgmii_low_q;
			end
			fanp_pkg::OFF_EXP: begin
				rdata_d = exp_val;
			end
			fanp_pkg::OFF_NP_TX: begin
				rdata_d = np_tx_q;
				rdata_d[fanp_pkg::CW_TOGGLE] = toggle_q;
			end
			fanp_pkg::OFF_NP_RX: begin
				rdata_d = np_rx_q;
			end
			fanp_pkg::OFF_IRQ_STAT: begin
				rdata_d[fanp_pkg::IRQ_W-1:0] = irq_stat;
			end
			fanp_pkg::OFF_IRQ_EN: begin
				rdata_d[fanp_pkg::IRQ_W-1:0] = irq_en;
			end
			default: begin
				rdata_d = 16'h0000;
			end
		endcase
	end

	// Read data stand one cycle after the strobe only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign rdata = rdata_q;
endmodule

// [tb/fanp_lp_model.sv]
// Link partner model: config groups, pages, next-page consumption
`timescale 1ns/1ps
module fanp_lp_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link,
	input wire logic slow,
	input wire logic send,
	input wire logic nxt,
	input wire logic [15:0] word,
	input wire logic np_loaded,
	output fanp_pkg::fanp_rx_s rx,
	output fanp_pkg::fanp_page_s page,
	output logic np_tx_taken
);
	logic [1:0] wait_q;
	always_comb begin
		rx.sync_ok = link;
		rx.link_up = link;
		rx.an_enable = 1'b1;
		rx.group_valid = link;
		rx.group = link ? 16'h01a0 : 16'hfe5f;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			page <= '0;
		end else begin
			page.page_valid <= send;
			page.is_next_page <= send ? nxt : ~page.is_next_page;
			page.code_word <= send ? word : ~page.code_word;
		end
	end
	// Consumes a loaded page promptly or after a stall
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_q <= 2'h0;
			np_tx_taken <= 1'b0;
		end else begin
			np_tx_taken <= np_loaded && wait_q == {slow, 1'b0};
			wait_q <= np_loaded && !np_tx_taken ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

// [tb/fanp_regs_props.sv]
// Assertion checker for the fiber negotiation register bank
`timescale 1ns/1ps
module fanp_regs_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [1:0] fiber_mode,
	input wire fanp_pkg::fanp_rx_s rx,
	input wire fanp_pkg::fanp_page_s page,
	input wire logic np_tx_taken,
	input wire logic np_loaded,
	input wire logic np_tx_active,
	input wire logic [15:0] np_tx_word,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic re, rn, pv, x1;
	assign re = rd && addr == fanp_pkg::OFF_EXP;
	assign rn = rd && addr == fanp_pkg::OFF_NP_RX;
	assign pv = page.page_valid;
	assign x1 = fiber_mode == 2'h1;
	local_np_a: assert property (
		re |=> rdata[2]) else $error("local next page bit low");
	exp_upper_a: assert property (
		re |=> rdata[15:4] == 12'h000) else $error("upper bits set");
	lp_np_zero_a: assert property (
		re && !x1 |=> !rdata[3]) else $error("partner np flag set");
	page_flag_a: assert property (
		pv ##1 re |=> rdata[1]) else $error("page flag missing");
	lh_clear_a: assert property (
		re && !pv ##1 !pv ##1 re && !pv |=> !rdata[1])
		else $error("page flag not cleared");
	np_load_a: assert property (
		wr && addr == fanp_pkg::OFF_NP_TX ##1 x1 |-> np_loaded)
		else $error("loaded flag missing");
	mode_gate_a: assert property (
		np_tx_active == x1 && (!np_loaded || x1))
		else $error("transmit page outside mode");
	toggle_a: assert property (
		pv && x1 ##1 !pv |=> np_tx_word[11] != $past(np_tx_word[11]))
		else $error("toggle not inverted");
	np_rx_load_a: assert property (
		pv && page.is_next_page && x1 ##1 rn && !pv
		|=> rdata == $past(page.code_word, 2)) else $error("np not stored");
	np_rx_clr_a: assert property (
		$fell(rx.link_up) && !pv ##1 !pv[*2] ##1 rn && !pv
		|=> rdata == 16'h0000) else $error("np not cleared");
endmodule
bind fanp_regs fanp_regs_props fanp_regs_props_inst (.clk_sys(clk_sys),
	.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.fiber_mode(fiber_mode), .rx(rx), .page(page), .np_loaded(np_loaded),
	.np_tx_taken(np_tx_taken), .np_tx_active(np_tx_active),
	.np_tx_word(np_tx_word), .irq(irq));

// [tb/testbench.sv]
// Self-checking bench for the fiber negotiation register bank
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] fiber_mode = 2'h1;
	logic link = 1'b0;
	logic slow = 1'b0;
	logic send = 1'b0;
	logic nxt = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] rdata, np_tx_word, lnp;
	logic [15:0] seed = 16'h0042;
	logic np_loaded, np_tx_active, irq, np_tx_taken;
	fanp_pkg::fanp_rx_s rx;
	fanp_pkg::fanp_page_s page;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	always #5 clk_sys = ~clk_sys;
	fanp_regs fanp_regs_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.fiber_mode(fiber_mode), .rx(rx), .page(page),
		.np_tx_taken(np_tx_taken), .np_loaded(np_loaded),
		.np_tx_active(np_tx_active), .np_tx_word(np_tx_word), .irq(irq));
	fanp_lp_model fanp_lp_model_inst (.clk_sys(clk_sys), .rst(rst),
		.link(link), .slow(slow), .send(send), .nxt(nxt), .word(word),
		.np_loaded(np_loaded), .rx(rx), .page(page),
		.np_tx_taken(np_tx_taken));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] exp_tx(input logic [15:0] v, input logic t);
		return (v & fanp_pkg::NP_TX_WMASK) | {4'h0, t, 11'h000};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		chk(rdata & m, e);
		@(posedge clk_sys);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic lp_send(input logic n, input logic [15:0] d);
		send <= 1'b1;
		nxt <= n;
		word <= d;
		@(posedge clk_sys);
		send <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd_chk(fanp_pkg::OFF_EXP, 16'hffff, 16'h0004);
		rd_chk(fanp_pkg::OFF_NP_TX, 16'hffff, 16'h2001);
		rd_chk(fanp_pkg::OFF_NP_RX, 16'hffff, 16'h0000);
		rd_chk(5'h1f, 16'hffff, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			slow <= i[0];
			seed = lfsr(seed);
			wr_reg(fanp_pkg::OFF_NP_TX, seed);
			#1;
			chk({15'h0, np_loaded}, 16'h0001);
			repeat (6) @(posedge clk_sys);
			chk(np_tx_word, exp_tx(seed, 1'b0));
			chk({15'h0, np_loaded}, 16'h0000);
		end
		lnp = seed;
		link <= 1'b1;
		repeat (8) @(posedge clk_sys);
		lp_send(1'b0, 16'h8001);
		@(posedge clk_sys);
		rd_chk(fanp_pkg::OFF_EXP, 16'hffff, 16'h000f);
		rd_chk(fanp_pkg::OFF_EXP, 16'hffff, 16'h000d);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			lp_send(1'b1, seed);
			@(posedge clk_sys);
			rd_chk(fanp_pkg::OFF_NP_RX, 16'hffff, seed);
		end
		lp_send(1'b0, 16'h0001);
		@(posedge clk_sys);
		rd_chk(fanp_pkg::OFF_NP_RX, 16'hffff, seed);
		rd_chk(fanp_pkg::OFF_EXP, 16'h0008, 16'h0000);
		rd_chk(fanp_pkg::OFF_NP_TX, 16'hffff, exp_tx(lnp, 1'b1));
		wr_reg(fanp_pkg::OFF_IRQ_EN, 16'h0001);
		lp_send(1'b0, 16'h0001);
		chk({15'h0, irq}, 16'h0001);
		@(posedge clk_sys);
		wr_reg(fanp_pkg::OFF_IRQ_CLR, 16'h000f);
		wr_reg(fanp_pkg::OFF_IRQ_EN, 16'h0000);
		lp_send(1'b0, 16'h0001);
		chk({15'h0, irq}, 16'h0000);
		@(posedge clk_sys);
		rd_chk(fanp_pkg::OFF_IRQ_STAT, 16'h0003, 16'h0001);
		lnp = seed;
		for (int m = 0; m < 4; m++) begin
			fiber_mode <= m[1:0];
			@(posedge clk_sys);
			seed = lfsr(seed);
			lp_send(1'b0, {1'b1, seed[14:0]});
			chk({15'h0, np_tx_active}, {15'h0, m == 1});
			@(posedge clk_sys);
			rd_chk(fanp_pkg::OFF_EXP, 16'h0008, {12'h0, m == 1, 3'h0});
			if (m == 3) begin
				rd_chk(fanp_pkg::OFF_LP_BASE, 16'h007f, {9'h0, seed[6:0]});
			end
			lp_send(1'b1, ~seed);
			@(posedge clk_sys);
			if (m == 1) begin
				lnp = ~seed;
			end
			rd_chk(fanp_pkg::OFF_NP_RX, 16'hffff, lnp);
		end
		fiber_mode <= 2'h1;
		lp_send(1'b1, 16'h5a5a);
		@(posedge clk_sys);
		link <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd_chk(fanp_pkg::OFF_NP_RX, 16'hffff, 16'h0000);
		rd_chk(fanp_pkg::OFF_EXP, 16'h0008, 16'h0000);
		rd_chk(fanp_pkg::OFF_IRQ_STAT, 16'h0004, 16'h0004);
		wr_reg(fanp_pkg::OFF_NP_TX, 16'hffff);
		wr_reg(fanp_pkg::OFF_SW_RST, 16'h0001);
		rd_chk(fanp_pkg::OFF_NP_TX, 16'hffff, 16'h2001);
		finish_test();
	end
endmodule
